// ==== core/dsa_pkg.sv ====
package dsa_pkg;

  localparam int SAMPLE_W = 24;
  localparam int NUM_CH   = 4;
  localparam int RATIO_W  = 10;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_TUNING    = 8'h04;
  localparam logic [7:0] ADDR_FRONTEND  = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0c;
  localparam logic [7:0] ADDR_DEVICE_ID = 8'h10;
  localparam logic [7:0] ADDR_RATIO     = 8'h14;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h18;
  localparam logic [7:0] ADDR_LATEST0   = 8'h20;
  localparam logic [7:0] ADDR_LATEST1   = 8'h24;
  localparam logic [7:0] ADDR_LATEST2   = 8'h28;
  localparam logic [7:0] ADDR_LATEST3   = 8'h2c;

  // Control fields
  localparam int CTRL_ENABLE_BIT     = 0;
  localparam int CTRL_HIGH_SPEED_BIT = 1;
  localparam int CTRL_CONTINUOUS_BIT = 2;

  // Front end fields
  localparam int FE_COUPLING_LSB   = 0;
  localparam int FE_EXCITATION_LSB = 4;

  // Status fields
  localparam int ST_LOADED_BIT  = 0;
  localparam int ST_OVERRUN_BIT = 1;
  localparam int ST_LEVEL_LSB   = 16;
  localparam int ST_LEVEL_W     = 16;

  // Timebase to sample ratios
  localparam logic [RATIO_W-1:0] RATIO_HIGH_RES   = 10'h200;
  localparam logic [RATIO_W-1:0] RATIO_HIGH_SPEED = 10'h100;

  localparam logic [31:0] TUNING_RESET = 32'h0000_0000;
  localparam int          PHASE_MSB    = 31;

  typedef enum logic [0:0] {
    PUSH_IDLE = 1'b0,
    PUSH_BUSY = 1'b1
  } push_state_t;

endpackage

// ==== core/dsa_sample_acquisition.sv ====
`timescale 1ns/1ps

// Contract
// - Samples are 24-bit two's complement codes, zero input reads all zeros.
// - Each completed conversion's sample words are pushed into a data FIFO.
// - Converter clock comes from a programmable timebase; ratio 512 or 256 by mode.
// - All four channels are sampled together on one common strobe.
// - Per-channel latest-value registers always hold the newest sample.
// - A newer sample overwrites an unread latest value silently, with no flag; a scan the FIFO cannot take is dropped and sets overrun.
// - Enabled sensor excitation forces that input's coupling to AC.
// - The 0..7 rotary identifier is read and reported to the host.
// - Indicator shows amber while firmware loads, green once loaded.
module dsa_sample_acquisition
  import dsa_pkg::*;
#(
  parameter int FIFO_DEPTH = 256
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     conv_clk,
  output logic                     sample_strobe,
  input  wire logic                conv_done,
  input  wire logic [SAMPLE_W-1:0] sample_ch0,
  input  wire logic [SAMPLE_W-1:0] sample_ch1,
  input  wire logic [SAMPLE_W-1:0] sample_ch2,
  input  wire logic [SAMPLE_W-1:0] sample_ch3,
  input  wire logic [2:0]          device_id_sel,
  input  wire logic                fw_load_done,
  output logic                     led_amber,
  output logic                     led_green,
  output logic      [NUM_CH-1:0]   coupling_ac,
  output logic      [NUM_CH-1:0]   excitation_en
);

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int CW = AW + 1;
  // Room for one whole scan
  localparam logic [CW-1:0] ROOM_LIMIT = CW'(FIFO_DEPTH - NUM_CH);
  localparam logic [1:0]    LAST_CH    = 2'(NUM_CH - 1);

  typedef struct packed {
    logic [31:0]                      prdata;
    logic                             pready;
    logic                             pslverr;
    logic                             enable;
    logic                             high_speed;
    logic                             continuous;
    logic [31:0]                      tuning;
    logic [31:0]                      phase;
    logic [RATIO_W-1:0]               tick_cnt;
    logic                             conv_clk;
    logic                             sample_strobe;
    logic [NUM_CH-1:0]                coupling_sel;
    logic [NUM_CH-1:0]                excitation;
    logic [NUM_CH-1:0]                coupling_ac;
    logic [NUM_CH-1:0]                excitation_en;
    logic [NUM_CH-1:0][SAMPLE_W-1:0]  latest;
    logic [NUM_CH-1:0][SAMPLE_W-1:0]  hold;
    push_state_t                      push_state;
    logic [1:0]                       push_ch;
    logic [AW-1:0]                    wptr;
    logic [AW-1:0]                    rptr;
    logic [CW-1:0]                    count;
    logic                             overrun;
    logic [2:0]                       device_id;
    logic                             fw_loaded;
    logic                             led_amber;
    logic                             led_green;
  } state_t;

  // Every field named, so a field added later cannot escape reset
  localparam state_t RESET_STATE = '{
    prdata:        '0,
    pready:        1'b0,
    pslverr:       1'b0,
    enable:        1'b0,
    high_speed:    1'b0,
    continuous:    1'b0,
    tuning:        TUNING_RESET,
    phase:         '0,
    tick_cnt:      '0,
    conv_clk:      1'b0,
    sample_strobe: 1'b0,
    coupling_sel:  '0,
    excitation:    '0,
    coupling_ac:   '0,
    excitation_en: '0,
    latest:        '0,
    hold:          '0,
    push_state:    PUSH_IDLE,
    push_ch:       '0,
    wptr:          '0,
    rptr:          '0,
    count:         '0,
    overrun:       1'b0,
    device_id:     '0,
    fw_loaded:     1'b0,
    led_amber:     1'b1,
    led_green:     1'b0
  };

  state_t              s;
  state_t              n;
  logic [SAMPLE_W-1:0] mem [FIFO_DEPTH];
  logic                push_en;
  logic [SAMPLE_W-1:0] push_word;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [31:0]        rd;
    logic               hit;
    logic               tick;
    logic               pop;
    logic [RATIO_W-1:0] ratio;
    rd        = 32'h0000_0000;
    hit       = 1'b1;
    tick      = 1'b0;
    pop       = 1'b0;
    ratio     = s.high_speed ? RATIO_HIGH_SPEED : RATIO_HIGH_RES;
    push_en   = 1'b0;
    push_word = s.hold[s.push_ch];
    n         = s;

    // Timebase: phase accumulator, MSB is the converter clock
    // Zero tuning holds the converter clock still
    n.sample_strobe = 1'b0;
    if (s.enable) begin
      n.phase = s.phase + s.tuning;
      tick    = n.phase[PHASE_MSB] & ~s.phase[PHASE_MSB];
    end else begin
      n.phase    = 32'h0000_0000;
      n.tick_cnt = '0;
    end
    n.conv_clk = n.phase[PHASE_MSB];
    // Strobe on the last tick of each ratio period
    if (tick) begin
      if (s.tick_cnt == ratio - 10'h001) begin
        n.tick_cnt      = '0;
        n.sample_strobe = 1'b1;
      end else begin
        n.tick_cnt = s.tick_cnt + 10'h001;
      end
    end

    // Front end: excitation overrides the coupling choice
    for (int ch = 0; ch < NUM_CH; ch++) begin
      n.coupling_ac[ch] = s.coupling_sel[ch] | s.excitation[ch];
    end
    n.excitation_en = s.excitation;

    // Selector is a slow level, taken as synchronous
    n.device_id = device_id_sel;

    // Latest values: overwritten on every scan, no lost-data flag
    if (conv_done) begin
      n.latest = {sample_ch3, sample_ch2, sample_ch1, sample_ch0};
    end

    // Register read mux
    case (paddr)
      ADDR_CTRL: begin
        rd[CTRL_ENABLE_BIT]     = s.enable;
        rd[CTRL_HIGH_SPEED_BIT] = s.high_speed;
        rd[CTRL_CONTINUOUS_BIT] = s.continuous;
      end
      ADDR_TUNING: rd = s.tuning;
      ADDR_FRONTEND: begin
        rd[FE_COUPLING_LSB +: NUM_CH]   = s.coupling_ac;
        rd[FE_EXCITATION_LSB +: NUM_CH] = s.excitation;
      end
      ADDR_STATUS: begin
        rd[ST_LOADED_BIT]                = s.fw_loaded;
        rd[ST_OVERRUN_BIT]               = s.overrun;
        rd[ST_LEVEL_LSB +: ST_LEVEL_W]   = ST_LEVEL_W'(s.count);
      end
      ADDR_DEVICE_ID: rd = 32'(s.device_id);
      ADDR_RATIO:     rd = 32'(ratio);
      ADDR_FIFO_DATA: rd = (s.count != '0) ? 32'(mem[s.rptr]) : 32'h0000_0000;
      ADDR_LATEST0:   rd = 32'(s.latest[0]);
      ADDR_LATEST1:   rd = 32'(s.latest[1]);
      ADDR_LATEST2:   rd = 32'(s.latest[2]);
      ADDR_LATEST3:   rd = 32'(s.latest[3]);
      default:        hit = 1'b0;
    endcase

    // APB: one wait state, commit at the edge that sees pready high
    if (psel && penable && !s.pready) begin
      n.pready  = 1'b1;
      n.prdata  = rd;
      n.pslverr = ~hit;
    end else if (psel && penable && s.pready) begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (pwrite) begin
        case (paddr)
          ADDR_CTRL: begin
            n.enable     = pwdata[CTRL_ENABLE_BIT];
            n.high_speed = pwdata[CTRL_HIGH_SPEED_BIT];
            n.continuous = pwdata[CTRL_CONTINUOUS_BIT];
          end
          ADDR_TUNING: n.tuning = pwdata;
          ADDR_FRONTEND: begin
            n.coupling_sel = pwdata[FE_COUPLING_LSB +: NUM_CH];
            n.excitation   = pwdata[FE_EXCITATION_LSB +: NUM_CH];
          end
          ADDR_STATUS: begin
            if (pwdata[ST_OVERRUN_BIT]) begin
              n.overrun = 1'b0;
            end
          end
          default: ;
        endcase
      end else if (paddr == ADDR_FIFO_DATA && s.count != '0) begin
        pop    = 1'b1;
        n.rptr = s.rptr + AW'(1);
      end
    end else if (s.pready) begin
      // Master left early; pready must not stand a second cycle
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
    end

    // FIFO fill: a scan is taken whole or not at all, so the stream
    // never carries a partial scan that would shift channel positions
    unique case (s.push_state)
      PUSH_IDLE: begin
        if (conv_done && s.continuous) begin
          if (s.count <= ROOM_LIMIT) begin
            n.hold       = {sample_ch3, sample_ch2, sample_ch1, sample_ch0};
            n.push_ch    = 2'h0;
            n.push_state = PUSH_BUSY;
          end else begin
            n.overrun = 1'b1;
          end
        end
      end
      PUSH_BUSY: begin
        push_en = 1'b1;
        n.wptr  = s.wptr + AW'(1);
        if (s.push_ch == LAST_CH) begin
          n.push_state = PUSH_IDLE;
        end else begin
          n.push_ch = s.push_ch + 2'h1;
        end
        // A scan arriving mid-push is dropped whole
        if (conv_done && s.continuous) begin
          n.overrun = 1'b1;
        end
      end
    endcase
    // Push and pop may meet in one cycle; the level nets them
    n.count = s.count + CW'(push_en) - CW'(pop);

    // Firmware load indicator
    // Loaded is sticky until reset
    n.fw_loaded = s.fw_loaded | fw_load_done;
    n.led_green = n.fw_loaded;
    n.led_amber = ~n.fw_loaded;
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= RESET_STATE;
    end else begin
      s <= n;
    end
  end

  // Sample storage has no reset; contents are qualified by count
  always_ff @(posedge pclk) begin
    if (push_en) begin
      mem[s.wptr] <= push_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign conv_clk      = s.conv_clk;
  assign sample_strobe = s.sample_strobe;
  assign led_amber     = s.led_amber;
  assign led_green     = s.led_green;
  assign coupling_ac   = s.coupling_ac;
  assign excitation_en = s.excitation_en;

endmodule

// ==== tb/dsa_checker_sva.sv ====
`timescale 1ns/1ps
module dsa_checker
  import dsa_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        sample_strobe,
  input wire logic        fw_load_done,
  input wire logic        led_amber,
  input wire logic        led_green,
  input wire logic [3:0]  coupling_ac,
  input wire logic [3:0]  excitation_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rdy_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdy_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");
  a_led_excl: assert property (led_amber != led_green)
    else $error("indicator colours clash");
  a_green_keep: assert property (led_green |=> led_green)
    else $error("green indicator dropped");
  a_fw_green: assert property (fw_load_done |-> ##[1:2] led_green)
    else $error("green late after load");
  a_exc_ac: assert property ((excitation_en & ~coupling_ac) == 4'h0)
    else $error("excited input not ac");
  a_strobe_one: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe wider than one cycle");
  cover property (pslverr);
  cover property (sample_strobe);
  cover property ($rose(led_green));
endmodule
////////////////////////////////////////////////////////////////////////
bind dsa_sample_acquisition dsa_checker i_dsa_checker (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .prdata, .sample_strobe, .fw_load_done,
  .led_amber, .led_green, .coupling_ac, .excitation_en);

// ==== tb/dsa_adc_model.sv ====
`timescale 1ns/1ps
module dsa_adc_model
  import dsa_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        sample_strobe,
  input  wire logic [95:0] scan,
  output logic             conv_done,
  output logic      [95:0] data
);
  logic [3:0] dly = 4'h0;
  initial begin
    conv_done = 1'b0;
    data = 96'h0;
  end
  // Lines toggle outside a result so stale data never looks valid
  always @(posedge pclk) begin
    conv_done <= (dly == 4'h1);
    data <= (dly == 4'h1) ? scan : ~data;
    dly <= sample_strobe ? 4'h3 : (dly != 4'h0 ? dly - 4'h1 : dly);
  end
endmodule

// ==== tb/dsa_sample_acquisition_bench.sv ====
`timescale 1ns/1ps
module dsa_sample_acquisition_bench;
  import dsa_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic conv_clk, sample_strobe, conv_done, fw_load_done, led_amber, led_green;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, d, s;
  logic [2:0]  device_id_sel;
  logic [3:0]  coupling_ac, excitation_en;
  logic [95:0] scan, data;
  logic [31:0] q[$];
  int n_fail = 0, n_checks = 0, cyc = 0, nscan = 0, t0, t1;
  dsa_sample_acquisition #(.FIFO_DEPTH(8)) i_dsa_sample_acquisition (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_clk,
    .sample_strobe, .conv_done, .sample_ch0(data[23:0]), .sample_ch1(data[47:24]),
    .sample_ch2(data[71:48]), .sample_ch3(data[95:72]), .device_id_sel,
    .fw_load_done, .led_amber, .led_green, .coupling_ac, .excitation_en);
  dsa_adc_model i_dsa_adc_model (.pclk, .sample_strobe, .scan, .conv_done, .data);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic strobe_at(output int t);
    do @(posedge pclk); while (sample_strobe !== 1'b1);
    t = cyc;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard: whole run needs well under 8000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
    if (conv_done === 1'b1) begin
      for (int c = 0; c < 4; c++) q.push_back({8'h0, data[c*24+:24]});
      nscan++;
      scan <= {$urandom, $urandom, $urandom};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fw_load_done, scan, device_id_sel} = '0;
    presetn = 1'b0;
    s = $urandom(32'h8b86);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("leds", {led_amber, led_green}, 2'b10);
    for (int i = 0; i < 8; i++) begin
      device_id_sel <= 3'(i);
      apb(1'b0, ADDR_DEVICE_ID, 0);
      chk("id", rd, i);
    end
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hf0 : $urandom & 32'hff;
      apb(1'b1, ADDR_FRONTEND, d);
      apb(1'b0, ADDR_FRONTEND, 0);
      chk("fe", rd, {d[7:4], d[3:0] | d[7:4]});
      chk("ac", coupling_ac, d[3:0] | d[7:4]);
      chk("exc", excitation_en, d[7:4]);
    end
    apb(1'b0, 8'h1c, 0);
    chk("unmapped", rd, 0);
    chk("slverr", err, 1);
    fw_load_done <= 1'b1;
    @(posedge pclk);
    fw_load_done <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("leds", {led_amber, led_green}, 2'b01);
    $display("done registers");
    apb(1'b1, ADDR_TUNING, 32'h8000_0000);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ADDR_CTRL, m ? 32'h3 : 32'h1);
      apb(1'b0, ADDR_RATIO, 0);
      chk("ratio", rd, m ? 256 : 512);
      strobe_at(t0);
      strobe_at(t1);
      chk("period", t1 - t0, m ? 512 : 1024);
      apb(1'b1, ADDR_CTRL, 0);
      // Also lets the last conversion land before the queue is flushed
      repeat (2) @(posedge pclk);
      chk("clk idle", conv_clk, 0);
    end
    $display("done timebase");
    scan <= {24'h800000, 24'h7fffff, 24'h000001, 24'h000000};
    q.delete();
    nscan = 0;
    apb(1'b1, ADDR_CTRL, 32'h7);
    while (nscan < 3) @(posedge pclk);
    apb(1'b1, ADDR_CTRL, 0);
    apb(1'b0, ADDR_STATUS, 0);
    chk("status", rd, {16'd8, 16'h3});
    apb(1'b1, ADDR_STATUS, 32'h2);
    apb(1'b0, ADDR_STATUS, 0);
    chk("overrun clear", rd, {16'd8, 16'h1});
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ADDR_FIFO_DATA, 0);
      chk("fifo", rd, q[i]);
    end
    apb(1'b0, ADDR_FIFO_DATA, 0);
    chk("empty", rd, 0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b0, ADDR_LATEST0 + 8'(4 * c), 0);
      chk("latest", rd, q[8+c]);
    end
    $display("done stream");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset leds", {led_amber, led_green}, 2'b10);
    presetn <= 1'b1;
    apb(1'b0, ADDR_STATUS, 0);
    chk("reset status", rd, 0);
    $display("done reset");
    results();
  end
endmodule
